// ===== icf_pkg.sv
// package of offsets, field positions and reset values for the interrupt control block
package icf_pkg;
	localparam logic [11:0] ICF_OFF_GLOBAL_CTRL = 12'h000;
	localparam logic [11:0] ICF_OFF_STATE       = 12'h004;
	localparam logic [11:0] ICF_OFF_FLAGS_SYS   = 12'h008;
	localparam logic [11:0] ICF_OFF_FLAGS_AT    = 12'h00c;
	localparam logic [11:0] ICF_OFF_FLAGS_SD    = 12'h010;
	localparam logic [11:0] ICF_OFF_ENABLES     = 12'h014;
	localparam logic [11:0] ICF_OFF_PRIORITY    = 12'h018;
	localparam logic [11:0] ICF_OFF_CORE        = 12'h01c;

	localparam int ICF_BIT_GHIGH   = 7;
	localparam int ICF_BIT_GLOW    = 6;
	localparam int ICF_BIT_PRIO_ON = 5;
	localparam int ICF_BIT_EXT2    = 2;
	localparam int ICF_BIT_EXT1    = 1;
	localparam int ICF_BIT_EXT0    = 0;
	localparam int ICF_BIT_PINCHG  = 7;
	localparam int ICF_BIT_CLKSW   = 3;
	localparam int ICF_BIT_SOFT    = 0;
	localparam int ICF_NSRC        = 24;

	// writable control bits: 7,6,5 and 2..0
	localparam logic [7:0] ICF_CTRL_WMASK  = 8'he7;
	localparam logic [7:0] ICF_CTRL_RESET  = 8'h07;
	localparam logic [7:0] ICF_FLAGS_RESET = 8'h00;
	// bits of the third flag register that software may clear
	localparam logic [7:0] ICF_SD_WMASK    = 8'h0f;
	// all sources high priority after reset
	localparam logic [23:0] ICF_PRIO_RESET = 24'hffffff;

	typedef enum logic [1:0] {
		ICF_ST_MAIN     = 2'b00,
		ICF_ST_LOW      = 2'b01,
		ICF_ST_HIGH     = 2'b10,
		ICF_ST_HIGH_NST = 2'b11
	} icf_state_t;
endpackage

// ===== icf_top.sv
// interrupt control, state tracking and request flag registers behind an apb slave
//
// How it works
// - without priority levels, bit 7 set allows all unmasked interrupts, clear blocks all.
// - with priority levels, low interrupts need both bit 7 and the low enable.
// - bit 6 gates low-priority interrupts; reads zero when priority levels are off.
// - bit 5 turns on two levels; cleared, every source counts as high.
// - edge selects bits 2..0: one rising, zero falling; all reset to one.
// - control bits 4 and 3 always read zero.
// - state reads 11 for nested high routine, 10 for high entered from main.
// - state reads 01 in low routine, 00 in main; resets to 00.
// - flags set on their event regardless of individual or global enables.
// - hardware-set flags hold until software writes zero; reset to zero.
// - pin-change flag is read-only and follows the per-pin flags.
// - clock-switch flag never raises the wake request.
// - software flag bit 0 is written one to request, zero to withdraw.
// - first flag register maps pin change down to software interrupt.
// - second flag register maps acquisition flags down to external 0, all writable.
// - third register bits 7-4 mirror serial conditions, read-only.
// - third register bits 3-0 are dma flags set by hardware, cleared by software.
// - a valid edge of selected polarity on an external input sets its flag.
// - wake request on any enabled pending event except clock switch, ignoring global enables.
// - after reset every source is high priority.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module icf_top #(
	parameter int NUM_SRC = icf_pkg::ICF_NSRC,
	parameter int NUM_EXT = 3
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  ext_irq_input,
	input  wire logic        per_pin_change_flags,
	input  wire logic [6:1]  sys_events,
	input  wire logic [6:0]  at_events,
	input  wire logic [3:0]  serial_levels,
	input  wire logic [3:0]  dma_events,
	input  wire logic        ack_high,
	input  wire logic        ack_low,
	input  wire logic        ret_service,
	output logic             irq_high,
	output logic             irq_low,
	output logic             wake_req,
	output logic [1:0]       ext12_flags,
	output icf_pkg::icf_state_t svc_state
);
	import icf_pkg::*;

	logic [7:0]  ctrl_q;
	logic [7:0]  fsys_q;
	logic [7:0]  fat_q;
	logic [3:0]  fdma_q;
	logic [1:0]  fext_q;
	logic [23:0] enable_q;
	logic [23:0] prio_q;
	icf_state_t  state_q;
	logic [2:0]  ext_s1_q;
	logic [2:0]  ext_s2_q;
	logic [2:0]  ext_s3_q;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic [3:0]  ser_s1_q;
	logic [3:0]  ser_s2_q;
	logic [2:0]  edge_hit;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wbyte;
	logic [23:0] flags;
	logic [23:0] pend;
	logic        prio_on;
	logic        pend_high;
	logic        pend_low;
	logic [7:0]  ctrl_view;
	logic [31:0] rdata_d;
	logic        bad_addr;
	logic        wr_ctrl;
	logic        wr_sys;
	logic        wr_at;
	logic        wr_sd;
	logic        wr_core;
	logic        wr_enab;
	logic        wr_prio;
	logic [2:0]  ext_rise;
	logic [2:0]  ext_fall;
	logic [23:0] wake_mask;

	// source vector and edge logic are laid out for these sizes only
	generate
		if (NUM_SRC != 24) begin : g_bad_src
			$error("icf_top: NUM_SRC must be 24");
		end
		if (NUM_EXT != 3) begin : g_bad_ext
			$error("icf_top: NUM_EXT must be 3");
		end
	endgenerate

	// zero wait states: every register answers in the access phase
	assign pready = 1'b1;
	// byte registers need the low strobe; wide ones take the whole word
	assign wr_en  = psel && penable && pwrite && pstrb[0];
	assign rd_en  = psel && penable && !pwrite;
	assign wbyte  = pwdata[7:0];

	// one strobe per register keeps the write decode in one place
	assign wr_ctrl = wr_en && paddr == ICF_OFF_GLOBAL_CTRL;
	assign wr_sys  = wr_en && paddr == ICF_OFF_FLAGS_SYS;
	assign wr_at   = wr_en && paddr == ICF_OFF_FLAGS_AT;
	assign wr_sd   = wr_en && paddr == ICF_OFF_FLAGS_SD;
	assign wr_core = wr_en && paddr == ICF_OFF_CORE;
	assign wr_enab = psel && penable && pwrite && paddr == ICF_OFF_ENABLES;
	assign wr_prio = psel && penable && pwrite && paddr == ICF_OFF_PRIORITY;

	// external pins are asynchronous: two stages, a third keeps the old level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 3'h0;
			ext_s2_q <= 3'h0;
			ext_s3_q <= 3'h0;
		end else begin
			ext_s1_q <= ext_irq_input;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// pin-change summary comes from other logic with no common clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= per_pin_change_flags;
			pin_s2_q <= pin_s1_q;
		end
	end

	// serial levels are mirrored only, so a plain two-stage sync suffices
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_s1_q <= 4'h0;
			ser_s2_q <= 4'h0;
		end else begin
			ser_s1_q <= serial_levels;
			ser_s2_q <= ser_s1_q;
		end
	end

	// edge detect per external input with its own polarity
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++) begin : g_edge
			// only synced stages are compared; stage one is never read here
			assign ext_rise[g] = ext_s2_q[g] && !ext_s3_q[g];
			assign ext_fall[g] = !ext_s2_q[g] && ext_s3_q[g];
			assign edge_hit[g] = ctrl_q[g] ? ext_rise[g] : ext_fall[g];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= ICF_CTRL_RESET;
		end else if (wr_ctrl) begin
			// unimplemented bits are dropped here, not only on read
			ctrl_q <= wbyte & ICF_CTRL_WMASK;
		end
	end

	// set wins over a clear written in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fsys_q <= ICF_FLAGS_RESET;
		end else begin
			if (wr_sys) begin
				fsys_q[6:1] <= wbyte[6:1] | sys_events;
				fsys_q[ICF_BIT_SOFT] <= wbyte[ICF_BIT_SOFT];
			end else begin
				fsys_q[6:1] <= fsys_q[6:1] | sys_events;
			end
			fsys_q[ICF_BIT_PINCHG] <= pin_s2_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fat_q <= ICF_FLAGS_RESET;
		end else if (wr_at) begin
			// event ored in so a clear cannot swallow a same-cycle set
			fat_q <= wbyte | {at_events, edge_hit[0]};
		end else begin
			fat_q <= fat_q | {at_events, edge_hit[0]};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fdma_q <= 4'h0;
		end else if (wr_sd) begin
			// writing one keeps a flag: software can only clear these
			fdma_q <= (wbyte[3:0] & fdma_q) | dma_events;
		end else begin
			fdma_q <= fdma_q | dma_events;
		end
	end

	// external 1 and 2 flags live in later registers; cleared through own core reg
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fext_q <= 2'h0;
		end else if (wr_core) begin
			fext_q <= wbyte[1:0] | edge_hit[2:1];
		end else begin
			fext_q <= fext_q | edge_hit[2:1];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 24'h0;
		end else if (wr_enab) begin
			enable_q <= pwdata[23:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_q <= ICF_PRIO_RESET;
		end else if (wr_prio) begin
			// one means high; ignored while priority levels are off
			prio_q <= pwdata[23:0];
		end
	end

	// source vector: [7:0] system, [15:8] analog/timer, [19:16] dma, [23:20] serial
	assign flags = {ser_s2_q, fdma_q, fat_q, fsys_q};
	assign pend = flags & enable_q;
	assign prio_on = ctrl_q[ICF_BIT_PRIO_ON];
	assign pend_high = |(pend & (prio_on ? prio_q : 24'hffffff));
	assign pend_low = prio_on && |(pend & ~prio_q);

	// clock switch flag masked out: it must not end sleep
	assign wake_mask = ~(24'h1 << ICF_BIT_CLKSW);
	// global enables ignored on purpose: a masked core must still wake
	// ext 1 and 2 have no enable in this block, so they cannot wake it
	assign wake_req = |(pend & wake_mask);

	always_comb begin
		irq_high = 1'b0;
		irq_low = 1'b0;
		if (!prio_on) begin
			irq_high = pend_high && ctrl_q[ICF_BIT_GHIGH] && state_q == ICF_ST_MAIN;
		end else begin
			irq_high = pend_high && ctrl_q[ICF_BIT_GHIGH]
				&& (state_q == ICF_ST_MAIN || state_q == ICF_ST_LOW);
			irq_low = pend_low && ctrl_q[ICF_BIT_GHIGH] && ctrl_q[ICF_BIT_GLOW]
				&& state_q == ICF_ST_MAIN;
		end
	end

	// core acknowledges entry; return pops one level
	// an ack is honoured only while its request still stands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ICF_ST_MAIN;
		end else begin
			case (state_q)
				ICF_ST_MAIN: begin
					if (ack_high && irq_high) begin
						state_q <= ICF_ST_HIGH;
					end else if (ack_low && irq_low) begin
						state_q <= ICF_ST_LOW;
					end
				end
				ICF_ST_LOW: begin
					if (ack_high && irq_high) begin
						state_q <= ICF_ST_HIGH_NST;
					end else if (ret_service) begin
						state_q <= ICF_ST_MAIN;
					end
				end
				ICF_ST_HIGH: begin
					if (ret_service) begin
						state_q <= ICF_ST_MAIN;
					end
				end
				ICF_ST_HIGH_NST: begin
					if (ret_service) begin
						state_q <= ICF_ST_LOW;
					end
				end
				default: begin
					state_q <= ICF_ST_MAIN;
				end
			endcase
		end
	end

	assign svc_state = state_q;
	assign ext12_flags = fext_q;

	always_comb begin
		ctrl_view = ctrl_q;
		if (!prio_on) begin
			ctrl_view[ICF_BIT_GLOW] = 1'b0;
		end
	end

	// unmapped offsets read zero and raise the error response
	always_comb begin
		rdata_d = 32'h0;
		bad_addr = 1'b0;
		case (paddr)
			ICF_OFF_GLOBAL_CTRL: rdata_d = {24'h0, ctrl_view};
			ICF_OFF_STATE:       rdata_d = {24'h0, state_q, 6'h00};
			ICF_OFF_FLAGS_SYS:   rdata_d = {24'h0, fsys_q};
			ICF_OFF_FLAGS_AT:    rdata_d = {24'h0, fat_q};
			ICF_OFF_FLAGS_SD:    rdata_d = {24'h0, ser_s2_q, fdma_q};
			ICF_OFF_ENABLES:     rdata_d = {8'h0, enable_q};
			ICF_OFF_PRIORITY:    rdata_d = {8'h0, prio_q};
			ICF_OFF_CORE:        rdata_d = {30'h0, fext_q};
			default:             bad_addr = 1'b1;
		endcase
	end

	assign prdata = rd_en ? rdata_d : 32'h0;
	assign pslverr = psel && penable && bad_addr;
endmodule
`default_nettype wire

// ===== icf_props.sv
// concurrent checks on the interrupt control block ports
`timescale 1ns/1ps
`default_nettype none
module icf_props (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	input wire logic                ack_high,
	input wire logic                ack_low,
	input wire logic                ret_service,
	input wire logic                irq_low,
	input wire icf_pkg::icf_state_t svc_state
);
	import icf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire rd = psel && penable && !pwrite;
	hole_refused_a: assert property (psel && penable && paddr > ICF_OFF_CORE |-> pslverr) else $error("no refusal");
	ctrl_reserved_a: assert property (rd && paddr == ICF_OFF_GLOBAL_CTRL |-> !prdata[4] && !prdata[3])
		else $error("control bits 4:3 set");
	low_hidden_a: assert property (rd && paddr == ICF_OFF_GLOBAL_CTRL && !prdata[5] |-> !prdata[6])
		else $error("low enable visible");
	state_read_a: assert property (rd && paddr == ICF_OFF_STATE |-> prdata == {24'h0, svc_state, 6'h0})
		else $error("state read");
	main_high_a: assert property (ack_high && svc_state == ICF_ST_MAIN |=> svc_state == ICF_ST_HIGH)
		else $error("high entry");
	nest_high_a: assert property (ack_high && svc_state == ICF_ST_LOW |=> svc_state == ICF_ST_HIGH_NST)
		else $error("nested entry");
	main_low_a: assert property (ack_low && !ack_high && svc_state == ICF_ST_MAIN |=> svc_state == ICF_ST_LOW)
		else $error("low entry");
	nest_ret_a: assert property (ret_service && !ack_high && svc_state == ICF_ST_HIGH_NST
		|=> svc_state == ICF_ST_LOW) else $error("nested return");
	low_block_a: assert property (svc_state != ICF_ST_MAIN |-> !irq_low) else $error("low preempts");
endmodule
bind icf_top icf_props chk (.*);
`default_nettype wire

// ===== icf_core_model.sv
// behavioural core: takes requests while go is high, returns on ret_req
`timescale 1ns/1ps
`default_nettype none
module icf_core_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic ret_req,
	input  wire logic irq_high,
	input  wire logic irq_low,
	output logic      ack_high,
	output logic      ack_low,
	output logic      ret_service
);
	// skip the edge after a take: the state has not moved yet
	wire busy = ack_high || ack_low;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_high <= 1'b0;
			ack_low <= 1'b0;
			ret_service <= 1'b0;
		end else begin
			ack_high <= go && irq_high && !busy;
			ack_low <= go && irq_low && !irq_high && !busy;
			ret_service <= ret_req && !ret_service;
		end
	end
endmodule
`default_nettype wire

// ===== icf_top_bench.sv
// self-checking bench of the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module icf_top_bench;
	import icf_pkg::*;
	localparam logic [11:0] CT = ICF_OFF_GLOBAL_CTRL, ST = ICF_OFF_STATE, SY = ICF_OFF_FLAGS_SYS;
	localparam logic [11:0] AT = ICF_OFF_FLAGS_AT, SD = ICF_OFF_FLAGS_SD, EN = ICF_OFF_ENABLES;
	logic        clk, rst_n, psel, penable, pwrite, go, ret_req, per_pin_change_flags;
	logic        pready, pslverr, irq_high, irq_low, wake_req, ack_high, ack_low, ret_service;
	logic [31:0] pwdata, prdata, rdv, v;
	logic [11:0] paddr;
	logic [6:0]  at_events, ea;
	logic [6:1]  sys_events, es;
	logic [3:0]  pstrb, serial_levels, dma_events, ed;
	logic [2:0]  ext_irq_input;
	logic [1:0]  ext12_flags;
	icf_state_t  svc_state;
	int          n_mismatch, checks_done, seed;
	icf_top uut (.*);
	icf_core_model core (.clk(clk), .rst_n(rst_n), .go(go), .ret_req(ret_req), .irq_high(irq_high),
		.irq_low(irq_low), .ack_high(ack_high), .ack_low(ack_low), .ret_service(ret_service));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until pready is seen high; data taken at that edge
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		rdv = prdata;
		{psel, penable} <= 2'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			give_verdict;
		end
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		xf(0, a, 0);
		chk(rdv, e);
	endtask
	task ev(input logic [16:0] s);
		@(posedge clk);
		{dma_events, at_events, sys_events} <= s;
		@(posedge clk);
		{dma_events, at_events, sys_events} <= '0;
	endtask
	initial begin
		seed = 32'h000a6d10;
		{rst_n, psel, penable, pwrite, go, ret_req, per_pin_change_flags, sys_events, at_events} = '0;
		{paddr, pwdata, dma_events, serial_levels, ext_irq_input, es, ea, ed, n_mismatch, checks_done} = '0;
		pstrb = 4'hf;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		rc(CT, 32'h07);
		rc(ST, 0);
		rc(SY, 0);
		rc(SD, 0);
		rc(ICF_OFF_PRIORITY, 32'hffffff);
		xf(1, CT, 32'hff);
		rc(CT, 32'he7);
		xf(1, CT, 32'hdf);
		rc(CT, 32'h87);
		rc(12'h020, 0);
		repeat (4) begin
			v = $random(seed);
			ev(v[16:0]);
			es |= v[5:0];
			ea |= v[12:6];
			ed |= v[16:13];
			rc(SY, {es, 1'b0});
			rc(AT, {ea, 1'b0});
			rc(SD, ed);
		end
		serial_levels <= 4'ha;
		per_pin_change_flags <= 1;
		xf(1, SY, 0);
		xf(1, AT, 0);
		xf(1, SD, 0);
		rc(SY, 32'h80);
		rc(SD, 32'ha0);
		{per_pin_change_flags, serial_levels} <= '0;
		repeat (4) @(posedge clk);
		rc(SY, 0);
		rc(SD, 0);
		xf(1, SY, 1);
		rc(SY, 1);
		ext_irq_input <= 3'b111;
		repeat (5) @(posedge clk);
		rc(AT, 1);
		chk(ext12_flags, 3);
		xf(1, CT, 0);
		xf(1, AT, 0);
		xf(1, ICF_OFF_CORE, 0);
		ext_irq_input <= 0;
		repeat (5) @(posedge clk);
		rc(AT, 1);
		rc(ICF_OFF_CORE, 3);
		xf(1, EN, 1);
		@(posedge clk);
		chk({irq_high, wake_req}, 1);
		xf(1, CT, 32'h80);
		@(posedge clk);
		chk({irq_high, irq_low}, 2);
		xf(1, EN, 8);
		ev(17'h4);
		@(posedge clk);
		chk({irq_high, wake_req}, 2);
		xf(1, SY, 1);
		xf(1, ICF_OFF_PRIORITY, 32'hfffffe);
		xf(1, EN, 1);
		xf(1, CT, 32'h60);
		@(posedge clk);
		chk(irq_low, 0);
		xf(1, CT, 32'he0);
		@(posedge clk);
		chk({irq_high, irq_low}, 1);
		go <= 1;
		repeat (4) @(posedge clk);
		rc(ST, 32'h40);
		xf(1, EN, 3);
		ev(17'h1);
		repeat (4) @(posedge clk);
		rc(ST, 32'hc0);
		go <= 0;
		for (int k = 0; k < 3; k++) begin
			if (k == 2) begin
				go <= 1;
				repeat (4) @(posedge clk);
				rc(ST, 32'h80);
				go <= 0;
			end
			ret_req <= 1;
			@(posedge clk);
			ret_req <= 0;
			repeat (3) @(posedge clk);
			rc(ST, k == 0 ? 32'h40 : 0);
		end
		give_verdict;
	end
endmodule
`default_nettype wire
